/* File: hdl/otpps_pkg.sv */
package otpps_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ         = 125;
    localparam int PULSE_NOM_US    = 100;
    localparam int PULSE_CYC       = PULSE_NOM_US * CLK_MHZ;
    localparam int SETUP_US        = 2;
    localparam int SETUP_CYC       = SETUP_US * CLK_MHZ;
    localparam int DFP_NS          = 130;
    localparam int DFP_CYC         = (DFP_NS * CLK_MHZ + 999) / 1000;
    localparam int OE_NS           = 150;
    localparam int OE_CYC          = (OE_NS * CLK_MHZ + 999) / 1000;
    localparam int MAX_REPULSE     = 10;
    localparam int ADDR_W          = 16;
    localparam int DATA_W          = 16;

    // ------------------------------------------------------------
    // supply levels, millivolts
    // ------------------------------------------------------------
    localparam logic [13:0] MV_OFF      = 14'h0000;
    localparam logic [13:0] MV_NOMINAL  = 14'h1388;
    localparam logic [13:0] MV_VCC_PROG = 14'h1964;
    localparam logic [13:0] MV_VPP_PROG = 14'h32c8;
    localparam logic [13:0] MV_ID       = 14'h2ee0;
    localparam int          ID_LINE_BIT = 9;
    localparam int          ID_SEL_BIT  = 0;

    typedef struct packed {
        logic [13:0] vcc_mv;
        logic [13:0] vpp_mv;
        logic        id_enable_line_hv;
    } otpps_supply_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              chip_enable_n;
        logic              output_enable_n;
        logic              program_strobe_n;
    } otpps_pins_t;

    typedef enum logic [1:0] {
        OTPPS_OP_PROGRAM,
        OTPPS_OP_ID_READ
    } otpps_op_t;

endpackage

/* File: hdl/otpps_timer.sv */
`timescale 1ns/1ns
// down counter: busy while counting, one-cycle done at expiry
module otpps_timer #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    // control
    input  wire logic             start,
    input  wire logic [WIDTH-1:0] load,
    output logic                  busy,
    output logic                  done
);
    logic [WIDTH-1:0] count;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            count <= '0;
            done  <= 1'b0;
        end else if (start) begin
            count <= load;
            done  <= 1'b0;
        end else begin
            done <= (count == WIDTH'(1));
            if (count != '0) begin
                count <= count - WIDTH'(1);
            end
        end
    end

    assign busy = (count != '0);
endmodule

/* File: hdl/otpps_sequencer.sv */
`timescale 1ns/1ns
// Contract
// - Each program strobe pulse lasts 100 us, always within 95 to 105 us.
// - The address counter is loaded with the first location before any pulse.
// - Core supply goes to 6.5 V and programming supply to 13.0 V before pulsing and stays.
// - The first pass gives exactly one pulse per address and no verify read.
// - A mismatching word gets up to 10 further pulses, each followed by a verify read.
// - A word still wrong after 10 extra pulses fails the device.
// - A verified word advances the address until every address has been checked.
// - After the loop both supplies drop to 5.0 V before the final check.
// - At nominal supplies every word is read and compared; any mismatch fails the part.
// - Core supply rises no later than and falls no earlier than the programming supply.
// - Identification reads hold other address lines low and the enable line at 12.0 V.
module otpps_sequencer #(
    parameter int                             ADDR_W     = otpps_pkg::ADDR_W,
    parameter int                             DATA_W     = otpps_pkg::DATA_W,
    parameter int                             PULSE_CYC  = otpps_pkg::PULSE_CYC,
    parameter int                             SETUP_CYC  = otpps_pkg::SETUP_CYC,
    parameter int                             MAX_REP    = otpps_pkg::MAX_REPULSE,
    parameter logic [otpps_pkg::ADDR_W-1:0]   LAST_ADDR  = 16'hffff
) (
    // clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    reset_n,
    // user command
    input  wire logic                    start,
    input  wire otpps_pkg::otpps_op_t    op,
    input  wire logic                    id_select,
    output logic                         busy,
    // source data: word for src_addr, valid same cycle
    output logic [ADDR_W-1:0]            src_addr,
    input  wire logic [DATA_W-1:0]       src_data,
    // memory pins
    output otpps_pkg::otpps_pins_t       pins,
    output logic [DATA_W-1:0]            data_out,
    output logic                         data_oe_n,
    input  wire logic [DATA_W-1:0]       data_in,
    // supplies
    output otpps_pkg::otpps_supply_t     supply,
    // status
    output logic                         done,
    output logic                         pass,
    output logic                         fail,
    output logic [DATA_W-1:0]            id_word,
    output logic [3:0]                   pulse_count
);
    typedef enum logic [3:0] {
        S_IDLE, S_VCC_UP, S_VPP_UP, S_P1_SET, S_P1_PULSE, S_V_SET, S_V_READ,
        S_V_PULSE, S_VPP_DN, S_VCC_DN, S_F_READ, S_ID_READ, S_OFF_VPP, S_OFF_VCC, S_END
    } otpps_state_t;

    localparam int TW = 16;

    otpps_state_t             state;
    otpps_state_t             next_state;
    logic [ADDR_W-1:0]        addr;
    logic [3:0]               reps;
    logic                     failed;
    logic                     id_mode;
    logic                     tmr_start;
    logic [TW-1:0]            tmr_load;
    logic                     tmr_busy;
    logic                     tmr_done;
    logic                     entering;

    function automatic logic [TW-1:0] cyc(input int n);
        return TW'(n);
    endfunction

    otpps_timer #(.WIDTH(TW)) u_timer (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .start   (tmr_start),
        .load    (tmr_load),
        .busy    (tmr_busy),
        .done    (tmr_done)
    );

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire at_last    = (addr == LAST_ADDR);
    wire match      = (data_in == src_data);
    wire reps_out   = (reps == 4'(MAX_REP));
    wire pulse_st   = (state == S_P1_PULSE) || (state == S_V_PULSE);
    wire read_st    = (state == S_V_READ) || (state == S_F_READ) || (state == S_ID_READ);
    wire high_v     = (state == S_VPP_UP) || (state >= S_P1_SET && state <= S_V_PULSE);

    always_comb begin
        next_state = state;
        case (state)
            S_IDLE:     if (start) next_state = S_VCC_UP;
            // program: core supply first, programming supply only after setup; ID read raises both at once
            S_VCC_UP:   if (tmr_done) next_state = id_mode ? S_ID_READ : S_VPP_UP;
            S_VPP_UP:   if (tmr_done) next_state = S_P1_SET;
            S_P1_SET:   if (tmr_done) next_state = S_P1_PULSE;
            S_P1_PULSE: if (tmr_done) next_state = at_last ? S_V_SET : S_P1_SET;
            S_V_SET:    if (tmr_done) next_state = S_V_READ;
            S_V_READ: begin
                if (tmr_done) begin
                    if (match) next_state = at_last ? S_VPP_DN : S_V_SET;
                    else if (reps_out) next_state = S_OFF_VPP;
                    else next_state = S_V_PULSE;
                end
            end
            S_V_PULSE:  if (tmr_done) next_state = S_V_READ;
            S_VPP_DN:   if (tmr_done) next_state = S_VCC_DN;
            S_VCC_DN:   if (tmr_done) next_state = S_F_READ;
            S_F_READ:   if (tmr_done && at_last) next_state = S_OFF_VPP;
            S_ID_READ:  if (tmr_done) next_state = S_OFF_VPP;
            S_OFF_VPP:  if (tmr_done) next_state = S_OFF_VCC;
            S_OFF_VCC:  if (tmr_done) next_state = S_END;
            S_END:      next_state = S_IDLE;
            default:    next_state = S_IDLE;
        endcase
    end

    assign entering  = (next_state != state) || (state == S_F_READ && tmr_done);
    assign tmr_start = entering && next_state != S_IDLE && next_state != S_END;
    assign tmr_load  = (next_state == S_P1_PULSE || next_state == S_V_PULSE)
                     ? cyc(PULSE_CYC) : cyc(SETUP_CYC);

    // ------------------------------------------------------------
    // state and counters
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state   <= S_IDLE;
            id_mode <= 1'b0;
        end else begin
            state <= next_state;
            if (state == S_IDLE && start) id_mode <= (op == otpps_pkg::OTPPS_OP_ID_READ);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            addr <= '0;
            reps <= 4'h0;
        end else if (state == S_IDLE && start) begin
            addr <= '0;
            reps <= 4'h0;
        end else if (tmr_done && ((state == S_P1_PULSE && !at_last)
                     || (state == S_V_READ && match && !at_last)
                     || (state == S_F_READ && !at_last))) begin
            addr <= addr + ADDR_W'(1);
            reps <= 4'h0;
        end else if (tmr_done && (state == S_P1_PULSE || state == S_VCC_DN
                     || (state == S_V_READ && match))) begin
            addr <= '0;
            reps <= 4'h0;
        end else if (state == S_V_READ && tmr_done && !match && !reps_out) begin
            reps <= reps + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // status
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            failed  <= 1'b0;
            done    <= 1'b0;
            pass    <= 1'b0;
            fail    <= 1'b0;
            id_word <= '0;
        end else begin
            if (state == S_IDLE && start) begin
                failed <= 1'b0;
                done   <= 1'b0;
                pass   <= 1'b0;
                fail   <= 1'b0;
            end
            if (state == S_V_READ && tmr_done && !match && reps_out) failed <= 1'b1;
            if (state == S_F_READ && tmr_done && !match) failed <= 1'b1;
            // identification word upper byte reads zero on the device
            if (state == S_ID_READ && tmr_done) id_word <= data_in;
            if (state == S_END) begin
                done <= 1'b1;
                pass <= !failed && !id_mode;
                fail <= failed;
            end
        end
    end

    // ------------------------------------------------------------
    // pins and supplies, registered
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pins      <= '{addr: '0, chip_enable_n: 1'b1, output_enable_n: 1'b1,
                           program_strobe_n: 1'b1};
            data_out  <= '0;
            data_oe_n <= 1'b1;
            supply    <= '{vcc_mv: otpps_pkg::MV_OFF, vpp_mv: otpps_pkg::MV_OFF,
                           id_enable_line_hv: 1'b0};
        end else begin
            if (id_mode) begin
                // all other address lines low, select bit chosen
                pins.addr <= ADDR_W'({15'h0000, id_select}) << otpps_pkg::ID_SEL_BIT;
            end else begin
                pins.addr <= addr;
            end
            pins.chip_enable_n    <= !(state != S_IDLE && state != S_END
                                       && state != S_OFF_VCC);
            pins.output_enable_n  <= !read_st;
            pins.program_strobe_n <= !(pulse_st && tmr_busy && !tmr_done);
            data_out              <= src_data;
            // release data bus while the device drives it for a read
            data_oe_n <= !(state == S_P1_SET || state == S_P1_PULSE
                           || state == S_V_SET || state == S_V_PULSE);
            supply.id_enable_line_hv <= id_mode && (state == S_ID_READ);
            case (state)
                S_VCC_UP, S_ID_READ: begin
                    supply.vcc_mv <= id_mode ? otpps_pkg::MV_NOMINAL : otpps_pkg::MV_VCC_PROG;
                    supply.vpp_mv <= id_mode ? otpps_pkg::MV_NOMINAL : otpps_pkg::MV_OFF;
                end
                S_VPP_DN: supply.vpp_mv <= otpps_pkg::MV_NOMINAL;
                S_VCC_DN: supply.vcc_mv <= otpps_pkg::MV_NOMINAL;
                S_OFF_VPP: supply.vpp_mv <= otpps_pkg::MV_OFF;
                S_OFF_VCC: supply.vcc_mv <= otpps_pkg::MV_OFF;
                default: begin
                    if (high_v) begin
                        supply.vcc_mv <= otpps_pkg::MV_VCC_PROG;
                        supply.vpp_mv <= otpps_pkg::MV_VPP_PROG;
                    end
                end
            endcase
        end
    end

    assign busy        = (state != S_IDLE);
    assign src_addr    = addr;
    assign pulse_count = reps;
endmodule

/* File: testbench/otpps_sequencer_props.sv */
`timescale 1ns/1ns
module otpps_sequencer_props #(
    parameter int PULSE_CYC = 20,
    parameter int MAX_REP   = 10
) (
    // clock and reset
    input wire logic                     sys_clk,
    input wire logic                     reset_n,
    // memory side
    input wire otpps_pkg::otpps_pins_t   pins,
    input wire logic                     data_oe_n,
    input wire otpps_pkg::otpps_supply_t supply,
    // status
    input wire logic                     start,
    input wire logic                     done,
    input wire logic                     pass,
    input wire logic                     fail,
    input wire logic [3:0]               pulse_count
);
    localparam int LO = PULSE_CYC * 95 / 100;
    localparam int HI = PULSE_CYC * 105 / 100;
    int low_cnt;
    // counts low cycles of the strobe, read at its rising edge
    always_ff @(posedge sys_clk) begin
        if (!reset_n || pins.program_strobe_n) begin
            low_cnt <= 0;
        end else begin
            low_cnt <= low_cnt + 1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_pulse_end; $rose(pins.program_strobe_n); endsequence
    sequence s_idle_done; done && !start; endsequence
    property p_width;
        s_pulse_end |-> low_cnt inside {[LO:HI]}; endproperty
    a_width: assert property (p_width) else $error("strobe width off");
    property p_pulse_supply; !pins.program_strobe_n |->
        supply.vcc_mv == otpps_pkg::MV_VCC_PROG && supply.vpp_mv == otpps_pkg::MV_VPP_PROG; endproperty
    a_pulse_supply: assert property (p_pulse_supply) else $error("pulse off level");
    property p_order;
        supply.vpp_mv != otpps_pkg::MV_OFF |-> supply.vcc_mv != otpps_pkg::MV_OFF; endproperty
    a_order: assert property (p_order) else $error("supply order broken");
    property p_count_max; pulse_count <= MAX_REP; endproperty
    a_count_max: assert property (p_count_max) else $error("too many pulses");
    property p_count_step; $changed(pulse_count) |->
        pulse_count == 4'h0 || pulse_count == $past(pulse_count) + 4'h1; endproperty
    a_count_step: assert property (p_count_step) else $error("pulse count jump");
    property p_sticky; s_idle_done |=> done; endproperty
    a_sticky: assert property (p_sticky) else $error("done dropped");
    property p_verdict; pass |-> done && !fail; endproperty
    a_verdict: assert property (p_verdict) else $error("bad verdict");
    property p_no_clash; !pins.output_enable_n |-> data_oe_n; endproperty
    a_no_clash: assert property (p_no_clash) else $error("data contention");
endmodule
bind otpps_sequencer otpps_sequencer_props #(.PULSE_CYC(PULSE_CYC), .MAX_REP(MAX_REP)) u_props (
    .sys_clk(sys_clk), .reset_n(reset_n), .pins(pins), .data_oe_n(data_oe_n),
    .supply(supply), .start(start), .done(done), .pass(pass), .fail(fail),
    .pulse_count(pulse_count));

/* File: testbench/otpps_otp_model.sv */
`timescale 1ns/1ns
module otpps_otp_model #(
    parameter logic [7:0] MAKER_CODE = 8'h5b, // arbitrary value
    parameter logic [7:0] TYPE_CODE  = 8'h6c  // arbitrary value
) (
    input  wire otpps_pkg::otpps_pins_t   pins,
    input  wire otpps_pkg::otpps_supply_t supply,
    input  wire logic [15:0]              data_out,
    output logic [15:0]                   data_in
);
    int          need [4];
    int          cnt [4];
    int          nom_reads [4];
    logic        early_read;
    logic        rd_open = 1'b0;
    logic [15:0] rd_addr = 16'h0000;
    logic [15:0] drive;
    logic [15:0] word [4] = '{default: 16'h0000};
    logic [15:0] last = 16'h0000;
    wire  [1:0]  a = pins.addr[1:0];
    wire         prog_lvl = supply.vcc_mv == otpps_pkg::MV_VCC_PROG
                            && supply.vpp_mv == otpps_pkg::MV_VPP_PROG;
    wire         nom_lvl  = supply.vcc_mv == otpps_pkg::MV_NOMINAL
                            && supply.vpp_mv == otpps_pkg::MV_NOMINAL;
    task automatic clear(input int n0, input int n1, input int n2, input int n3);
        need = '{n0, n1, n2, n3};
        cnt = '{0, 0, 0, 0};
        nom_reads = '{0, 0, 0, 0};
        early_read = 1'b0;
        rd_open = 1'b0;
    endtask
    initial clear(1, 1, 1, 1);
    // sampled at the falling edge: addr and data may move as the strobe rises
    always @(negedge pins.program_strobe_n) begin
        if (!pins.chip_enable_n && prog_lvl) begin
            cnt[a] += 1;
            word[a] = data_out;
        end
    end
    always @(negedge pins.output_enable_n) begin
        foreach (cnt[i]) if (prog_lvl && cnt[i] == 0) early_read = 1'b1;
    end
    // a nominal read opens on oe falling or on a new address while oe stays low
    always @(pins or supply) begin
        if (!pins.chip_enable_n && !pins.output_enable_n && nom_lvl
            && !supply.id_enable_line_hv) begin
            if (!rd_open || rd_addr != pins.addr) nom_reads[a] += 1;
            rd_open = 1'b1;
            rd_addr = pins.addr;
        end else begin
            rd_open = 1'b0;
        end
    end
    always_comb begin
        if (supply.id_enable_line_hv) drive = {8'h00, a[0] ? TYPE_CODE : MAKER_CODE};
        else if (cnt[a] >= need[a]) drive = word[a];
        else drive = ~word[a];
    end
    // released bus shows the inverse of the last word, never a stale copy
    always @(posedge pins.output_enable_n) last = drive;
    assign data_in = (pins.chip_enable_n || pins.output_enable_n) ? ~last : drive;
endmodule

/* File: testbench/otp_word_program_sequencer_bench.sv */
`timescale 1ns/1ns
module otp_word_program_sequencer_bench;
    logic                     sys_clk, reset_n, start, id_select, busy, data_oe_n;
    logic                     done, pass, fail;
    logic [3:0]               pulse_count;
    logic [15:0]              src_addr, src_data, data_out, data_in, id_word;
    otpps_pkg::otpps_op_t     op;
    otpps_pkg::otpps_pins_t   pins;
    otpps_pkg::otpps_supply_t supply;
    int                       num_errors = 0;
    int                       num_checks = 0;
    assign src_data = src_addr ^ 16'h3c5a;
    otpps_sequencer #(.PULSE_CYC(20), .SETUP_CYC(4), .LAST_ADDR(16'h0003)) uut (
        .sys_clk(sys_clk), .reset_n(reset_n), .start(start), .op(op), .id_select(id_select),
        .busy(busy), .src_addr(src_addr), .src_data(src_data), .pins(pins),
        .data_out(data_out), .data_oe_n(data_oe_n), .data_in(data_in), .supply(supply),
        .done(done), .pass(pass), .fail(fail), .id_word(id_word), .pulse_count(pulse_count));
    otpps_otp_model dev (.pins(pins), .supply(supply), .data_out(data_out), .data_in(data_in));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic run(input otpps_pkg::otpps_op_t kind, input logic [2:0] verdict);
        int n;
        n = 0;
        @(posedge sys_clk);
        op <= kind;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        // let the clearing of the previous verdict settle before polling
        #1;
        chk({15'h0, busy}, 16'h0001);
        while (done !== 1'b1 && n < 5000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk({13'h0, done, pass, fail}, {13'h0, verdict});
        chk({15'h0, busy}, 16'h0000);
    endtask
    task automatic t_program_pass();
        dev.clear(1, 11, 2, 4);
        run(otpps_pkg::OTPPS_OP_PROGRAM, 3'b110);
        chk({15'h0, dev.early_read}, 16'h0000);
        chk(16'(pulse_count), 16'h0000);
        chk(16'((otpps_pkg::PULSE_CYC * 8 >= 95000) && (otpps_pkg::PULSE_CYC * 8 <= 105000)), 16'h0001);
        for (int i = 0; i < 4; i++) begin
            chk(16'(dev.cnt[i]), 16'(dev.need[i]));
            chk(16'(dev.nom_reads[i]), 16'h0001);
        end
        $display("test program_pass finished");
    endtask
    task automatic t_program_fail();
        dev.clear(1, 1, 12, 1);
        run(otpps_pkg::OTPPS_OP_PROGRAM, 3'b101);
        chk(16'(dev.cnt[2]), 16'h000b);
        chk(16'(pulse_count), 16'(otpps_pkg::MAX_REPULSE));
        chk(16'(dev.cnt[3]), 16'h0001);
        chk(16'(dev.nom_reads[0]), 16'h0000);
        $display("test program_fail finished");
    endtask
    task automatic t_id_read();
        for (int s = 0; s < 2; s++) begin
            @(posedge sys_clk);
            id_select <= s[0];
            run(otpps_pkg::OTPPS_OP_ID_READ, 3'b100);
            chk(id_word, {8'h00, s[0] ? dev.TYPE_CODE : dev.MAKER_CODE});
        end
        $display("test id_read finished");
    endtask
    task automatic results();
        $display("checks=%0d mismatches=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // four runs of at most 5000 cycles each, with margin
    initial begin
        #200000;
        num_errors++;
        results();
    end
    initial begin
        reset_n = 1'b0;
        start = 1'b0;
        id_select = 1'b0;
        op = otpps_pkg::OTPPS_OP_PROGRAM;
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_program_pass();
        t_program_fail();
        t_id_read();
        results();
    end
endmodule
